// [hw/gcc_ctrl_upper.sv]
// global chip control register, bits 31 to 20, with the link power logic
// that those bits steer
// assumes config accesses and power events come from logic on i_ref_clk
`include "gcc_defines.svh"
`default_nettype none

module gcc_ctrl_upper
  import gcc_pkg::*;
(
  input  wire logic        i_ref_clk,                 // 40 MHz clock
  input  wire logic        i_rst_n,                   // fundamental reset
  input  wire logic        i_clk_en,                  // freezes all state
  input  wire logic [11:0] i_cfg_addr,                // config byte address
  input  wire logic        i_cfg_wr_en,               // config write strobe
  input  wire logic [3:0]  i_cfg_be,                  // byte enables
  input  wire logic [31:0] i_cfg_wdata,               // write data
  input  wire logic        i_cfg_rd_en,               // config read strobe
  output logic      [31:0] o_cfg_rdata,               // read data
  output logic             o_cfg_rd_valid,            // read data valid
  input  wire logic        i_eep_load_en,             // EEPROM word present
  input  wire logic [31:0] i_eep_data,                // EEPROM word
  input  wire logic [7:0]  i_min_power_value,         // lower minimum value
  input  wire logic        i_slot_limit_valid,        // limit message seen
  input  wire logic [7:0]  i_slot_limit_value,        // limit message value
  input  wire logic [1:0]  i_slot_limit_scale,        // limit message scale
  input  wire logic        i_aspm_l1_req,             // link asks for ASPM L1
  input  wire logic        i_aspm_l1_active,          // link is in ASPM L1
  input  wire logic        i_dstate_l1_active,        // link in D-state L1
  output logic             o_aspm_l1_grant,           // ASPM L1 permitted
  output logic             o_pll_power_down,          // PHY PLLs off, all PHYs
  output logic             o_lnkcap_aspm_l1_support,  // capability bit
  output logic      [1:0]  o_power_scale,             // scale to lower bits
  output logic             o_slot_limit_over          // limit above minimum
);

  // ========================================================================
  // stored fields
  logic       l1_pll_off_select_r;      // PLLs off in ASPM L1
  logic       low_power_link_enable_r;  // ASPM L1 enable
  logic       diag_r;                   // diagnostic bit, kept as written
  gcc_scale_t scale_r;                  // minimum power scale
  logic [31:0] rdata_r;                 // read data register
  logic       rd_valid_r;               // read answer flag
  logic       grant_r;                  // ASPM L1 grant
  logic       pll_down_r;               // PLL shutdown request
  logic       support_r;                // capability mirror
  logic [31:0] read_word;               // assembled register image
  logic       wr_hit;                   // write to this register
  logic       rd_hit;                   // read of this register

  gcc_pwr_if pwr ();                    // link to the comparator

  // ========================================================================
  // address decode
  function automatic logic gcc_addr_hit(input logic [11:0] addr);
    if (addr == `GCC_CTRL_OFFSET)
      return 1'b1;
    else
      return 1'b0;
  endfunction

  always_comb
  begin
    wr_hit = i_cfg_wr_en && gcc_addr_hit(i_cfg_addr);
    rd_hit = i_cfg_rd_en && gcc_addr_hit(i_cfg_addr);
  end

  // ========================================================================
  // field storage: EEPROM load wins over a config write
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      l1_pll_off_select_r     <= `GCC_RST_PLL_OFF;
      low_power_link_enable_r <= `GCC_RST_L1_EN;
      diag_r                  <= `GCC_RST_DIAG;
      scale_r                 <= gcc_scale_t'(`GCC_RST_SCALE);
    end
    else if (i_clk_en)
    begin
      if (i_eep_load_en)
      begin
        // image must hold zero in the diagnostic bit
        l1_pll_off_select_r     <= i_eep_data[`GCC_PLL_OFF_BIT];
        low_power_link_enable_r <= i_eep_data[`GCC_L1_EN_BIT];
        diag_r                  <= i_eep_data[`GCC_DIAG_BIT];
        scale_r                 <= gcc_scale_t'(i_eep_data[`GCC_SCALE_HI:`GCC_SCALE_LO]);
      end
      else if (wr_hit)
      begin
        // top lane: select, enable, diagnostic; bits 31 and 27:24 dropped
        if (i_cfg_be[`GCC_BE_TOP])
        begin
          l1_pll_off_select_r     <= i_cfg_wdata[`GCC_PLL_OFF_BIT];
          low_power_link_enable_r <= i_cfg_wdata[`GCC_L1_EN_BIT];
          diag_r                  <= i_cfg_wdata[`GCC_DIAG_BIT];
        end
        // second lane: only the scale field is writable
        if (i_cfg_be[`GCC_BE_MID])
          scale_r <= gcc_scale_t'(i_cfg_wdata[`GCC_SCALE_HI:`GCC_SCALE_LO]);
      end
    end
  end

  // ========================================================================
  // register image: reserved positions tied to zero
  always_comb
  begin
    read_word                                  = `GCC_RST_WORD;
    read_word[`GCC_RSVD_TOP_BIT]               = 1'b0;
    read_word[`GCC_PLL_OFF_BIT]                = l1_pll_off_select_r;
    read_word[`GCC_L1_EN_BIT]                  = low_power_link_enable_r;
    read_word[`GCC_DIAG_BIT]                   = diag_r;
    read_word[`GCC_RSVD_HI:`GCC_RSVD_LO]       = '0;
    read_word[`GCC_SCALE_HI:`GCC_SCALE_LO]     = scale_r;
  end

  // ========================================================================
  // read answer, one cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rdata_r    <= `GCC_RST_WORD;
      rd_valid_r <= 1'b0;
    end
    else if (i_clk_en)
    begin
      rd_valid_r <= i_cfg_rd_en;
      if (rd_hit)
        rdata_r <= read_word;
      else if (i_cfg_rd_en)
        rdata_r <= `GCC_RST_WORD;             // other offsets read zero
    end
  end

  // ========================================================================
  // link power control
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      grant_r    <= 1'b0;
      pll_down_r <= 1'b0;
      support_r  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      grant_r    <= i_aspm_l1_req && low_power_link_enable_r;
      // device-state L1 ignores the select bit
      pll_down_r <= i_dstate_l1_active
                    || (i_aspm_l1_active && l1_pll_off_select_r);
      support_r  <= low_power_link_enable_r;
    end
  end

  // ========================================================================
  // comparator hookup
  always_comb
  begin
    pwr.min_value   = i_min_power_value;
    pwr.scale       = scale_r;
    pwr.limit_valid = i_slot_limit_valid;
    pwr.limit_value = i_slot_limit_value;
    pwr.limit_scale = gcc_scale_t'(i_slot_limit_scale);
  end

  gcc_power_cmp u_cmp (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .pwr       (pwr.cmp)
  );

  // ========================================================================
  // outputs
  assign o_cfg_rdata              = rdata_r;
  assign o_cfg_rd_valid           = rd_valid_r;
  assign o_aspm_l1_grant          = grant_r;
  assign o_pll_power_down         = pll_down_r;
  assign o_lnkcap_aspm_l1_support = support_r;
  assign o_power_scale            = scale_r;
  assign o_slot_limit_over        = pwr.over_limit;

  // ========================================================================
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_top_zero;
    rd_valid_r |-> !rdata_r[`GCC_RSVD_TOP_BIT];
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("bit 31 read nonzero");

  property p_rsvd_zero;
    rd_valid_r |-> (rdata_r[`GCC_RSVD_HI:`GCC_RSVD_LO] == '0);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("bits 27 to 22 read nonzero");

  property p_aspm_pll;
    (i_clk_en && i_aspm_l1_active && !i_dstate_l1_active)
    |=> (pll_down_r == $past(l1_pll_off_select_r));
  endproperty
  a_aspm_pll: assert property (p_aspm_pll)
    else $error("PLL state in ASPM L1 does not follow select");

  property p_dstate_pll;
    (i_clk_en && i_dstate_l1_active) |=> pll_down_r;
  endproperty
  a_dstate_pll: assert property (p_dstate_pll)
    else $error("PLL kept on in device-state L1");

  property p_grant;
    (i_clk_en && i_aspm_l1_req) |=> (grant_r == $past(low_power_link_enable_r));
  endproperty
  a_grant: assert property (p_grant)
    else $error("ASPM L1 grant does not follow enable");

  property p_support;
    i_clk_en |=> (support_r == $past(low_power_link_enable_r));
  endproperty
  a_support: assert property (p_support)
    else $error("capability bit does not follow enable");

  property p_eep_load;
    (i_clk_en && i_eep_load_en)
    |=> (l1_pll_off_select_r == $past(i_eep_data[`GCC_PLL_OFF_BIT]))
        && (low_power_link_enable_r == $past(i_eep_data[`GCC_L1_EN_BIT]))
        && (scale_r == $past(i_eep_data[`GCC_SCALE_HI:`GCC_SCALE_LO]));
  endproperty
  a_eep_load: assert property (p_eep_load)
    else $error("EEPROM load not taken");

  sequence s_wr_rsvd;
    i_clk_en && wr_hit && !i_eep_load_en && i_cfg_be[`GCC_BE_TOP]
    && i_cfg_wdata[`GCC_RSVD_TOP_BIT];
  endsequence

  sequence s_rd_back;
    i_clk_en && rd_hit;
  endsequence

  property p_rsvd_write;
    s_wr_rsvd ##1 s_rd_back |=> (rd_valid_r && !rdata_r[`GCC_RSVD_TOP_BIT]
                                 && rdata_r[`GCC_PLL_OFF_BIT]
                                    == $past(i_cfg_wdata[`GCC_PLL_OFF_BIT], 2));
  endproperty
  a_rsvd_write: assert property (p_rsvd_write)
    else $error("write to reserved bit stored or writable bit lost");

endmodule // gcc_ctrl_upper

`default_nettype wire

// [hw/gcc_defines.svh]
// constants for the global chip control upper slice: offset, bit positions,
// reset values and power scale multipliers
// assumes inclusion by bare name from the package and the design modules
`ifndef GCC_DEFINES_SVH
`define GCC_DEFINES_SVH

// ==========================================================================
// register location and byte lanes
`define GCC_CTRL_OFFSET   12'h0B8
`define GCC_BE_TOP        3
`define GCC_BE_MID        2

// ==========================================================================
// field positions
`define GCC_RSVD_TOP_BIT  31
`define GCC_PLL_OFF_BIT   30
`define GCC_L1_EN_BIT     29
`define GCC_DIAG_BIT      28
`define GCC_RSVD_HI       27
`define GCC_RSVD_LO       22
`define GCC_SCALE_HI      21
`define GCC_SCALE_LO      20

// ==========================================================================
// reset values
`define GCC_RST_PLL_OFF   1'h0
`define GCC_RST_L1_EN     1'h0
`define GCC_RST_DIAG      1'h0
`define GCC_RST_SCALE     2'h0
`define GCC_RST_WORD      32'h0000_0000

// ==========================================================================
// scale multipliers, in thousandths of the power unit
`define GCC_MULT_X1       10'h3E8
`define GCC_MULT_X0P1     10'h064
`define GCC_MULT_X0P01    10'h00A
`define GCC_MULT_X0P001   10'h001
`define GCC_ZERO_VALUE    8'h00

`endif

// [hw/gcc_pkg.sv]
// types and shared arithmetic for the global chip control upper slice
// assumes gcc_defines.svh is on the include path
`include "gcc_defines.svh"
`default_nettype none

package gcc_pkg;

  // ========================================================================
  // power scale codes
  typedef enum logic [1:0] {
    GCC_SCALE_X1     = 2'h0,  // 1.0x
    GCC_SCALE_X0P1   = 2'h1,  // 0.1x
    GCC_SCALE_X0P01  = 2'h2,  // 0.01x
    GCC_SCALE_X0P001 = 2'h3   // 0.001x
  } gcc_scale_t;

  typedef logic [17:0] gcc_milli_t;  // power in thousandths of the unit

  // ========================================================================
  // value times scale, normalised to thousandths
  function automatic gcc_milli_t gcc_to_milli(input logic [7:0] value,
                                              input gcc_scale_t scale);
    logic [9:0] mult;
    mult = `GCC_MULT_X1;
    case (scale)
      GCC_SCALE_X1:     mult = `GCC_MULT_X1;
      GCC_SCALE_X0P1:   mult = `GCC_MULT_X0P1;
      GCC_SCALE_X0P01:  mult = `GCC_MULT_X0P01;
      default:          mult = `GCC_MULT_X0P001;
    endcase
    return gcc_milli_t'(value) * gcc_milli_t'(mult);
  endfunction

endpackage

`default_nettype wire

// [hw/gcc_pwr_if.sv]
// interface between the control register and the power comparator
// assumes gcc_pkg is compiled first
`default_nettype none

interface gcc_pwr_if;
  import gcc_pkg::*;
  logic [7:0] min_value;    // minimum power value field
  gcc_scale_t scale;        // minimum power scale field
  logic       limit_valid;  // slot power limit message seen
  logic [7:0] limit_value;  // limit value of that message
  gcc_scale_t limit_scale;  // limit scale of that message
  logic       over_limit;   // registered compare result

  // register side drives the operands
  modport ctrl (output min_value, output scale, output limit_valid,
                output limit_value, output limit_scale, input over_limit);
  // comparator side
  modport cmp  (input min_value, input scale, input limit_valid,
                input limit_value, input limit_scale, output over_limit);
endinterface

`default_nettype wire

// [hw/gcc_power_cmp.sv]
// slot power comparator: scales the minimum power value and checks it
// against each slot power limit received while that value is nonzero
// assumes operands on the same clock as i_ref_clk
`include "gcc_defines.svh"
`default_nettype none

module gcc_power_cmp
  import gcc_pkg::*;
(
  input  wire logic i_ref_clk,  // 40 MHz clock
  input  wire logic i_rst_n,    // async reset, active low
  input  wire logic i_clk_en,   // freezes state while low
  gcc_pwr_if.cmp    pwr         // operands and result
);

  // ========================================================================
  // scaled operands
  gcc_milli_t min_milli;    // minimum power in thousandths
  gcc_milli_t limit_milli;  // slot limit in thousandths
  logic       over_r;       // compare result

  always_comb
  begin
    min_milli   = gcc_to_milli(pwr.min_value, pwr.scale);
    limit_milli = gcc_to_milli(pwr.limit_value, pwr.limit_scale);
  end

  // ========================================================================
  // compare on each limit message, cleared while value is zero
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      over_r <= 1'b0;
    else if (i_clk_en)
    begin
      if (pwr.min_value == `GCC_ZERO_VALUE)
        over_r <= 1'b0;                          // comparison skipped
      else if (pwr.limit_valid)
        over_r <= (limit_milli > min_milli);
    end
  end

  assign pwr.over_limit = over_r;

  // ========================================================================
  // checks
  property p_zero_skips;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_clk_en && pwr.min_value == `GCC_ZERO_VALUE) |=> !over_r;
  endproperty
  a_zero_skips: assert property (p_zero_skips)
    else $error("compare not skipped for zero value");

  property p_scale_apart;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_clk_en && pwr.limit_valid && pwr.limit_scale == GCC_SCALE_X1
     && pwr.limit_value != `GCC_ZERO_VALUE && pwr.scale == GCC_SCALE_X0P001
     && pwr.min_value != `GCC_ZERO_VALUE) |=> over_r;
  endproperty
  a_scale_apart: assert property (p_scale_apart)
    else $error("scale decode wrong for 1.0x against 0.001x");

  property p_same_scale;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_clk_en && pwr.limit_valid && pwr.limit_scale == pwr.scale
     && pwr.min_value != `GCC_ZERO_VALUE)
    |=> (over_r == ($past(pwr.limit_value) > $past(pwr.min_value)));
  endproperty
  a_same_scale: assert property (p_same_scale)
    else $error("equal scale compare wrong");

endmodule // gcc_power_cmp

`default_nettype wire

// [verification/gcc_ctrl_upper_test.sv]
// self-checking bench for the global chip control upper slice
// assumes the hw/ package, interface and design modules are compiled first
`include "gcc_defines.svh"
`default_nettype none

module gcc_ctrl_upper_test
  import gcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // stimulus and observed signals
  logic        clk;          // 40 MHz reference clock
  logic        rst_n;        // fundamental reset, active low
  logic        clk_en;       // global clock enable
  logic [11:0] cfg_addr;     // config byte address
  logic        wr_en;        // config write strobe
  logic [3:0]  be;           // byte enables
  logic [31:0] wdata;        // write data
  logic        rd_en;        // config read strobe
  logic [31:0] rdata;        // read data
  logic        rd_valid;     // read data valid
  logic        eep_en;       // eeprom word strobe
  logic [31:0] eep_data;     // eeprom word
  logic [7:0]  min_val;      // minimum power value
  logic        lim_valid;    // slot limit message strobe
  logic [7:0]  lim_val;      // slot limit value
  logic [1:0]  lim_scale;    // slot limit scale
  logic        l1_req;       // link asks for low power
  logic        l1_active;    // link in link-managed low power
  logic        dstate_l1;    // link in device-state low power
  logic        grant;        // low power granted
  logic        pll_down;     // plls powered down
  logic        cap_support;  // capability bit
  logic [1:0]  pwr_scale;    // scale to lower bits
  logic        over;         // limit above minimum
  int          fails;        // mismatch count
  int          comparisons;  // comparison count

  // ==========================================================================
  // device under test
  gcc_ctrl_upper gcc_ctrl_upper_inst (
    .i_ref_clk                (clk),
    .i_rst_n                  (rst_n),
    .i_clk_en                 (clk_en),
    .i_cfg_addr               (cfg_addr),
    .i_cfg_wr_en              (wr_en),
    .i_cfg_be                 (be),
    .i_cfg_wdata              (wdata),
    .i_cfg_rd_en              (rd_en),
    .o_cfg_rdata              (rdata),
    .o_cfg_rd_valid           (rd_valid),
    .i_eep_load_en            (eep_en),
    .i_eep_data               (eep_data),
    .i_min_power_value        (min_val),
    .i_slot_limit_valid       (lim_valid),
    .i_slot_limit_value       (lim_val),
    .i_slot_limit_scale       (lim_scale),
    .i_aspm_l1_req            (l1_req),
    .i_aspm_l1_active         (l1_active),
    .i_dstate_l1_active       (dstate_l1),
    .o_aspm_l1_grant          (grant),
    .o_pll_power_down         (pll_down),
    .o_lnkcap_aspm_l1_support (cap_support),
    .o_power_scale            (pwr_scale),
    .o_slot_limit_over        (over)
  );

  // ==========================================================================
  // clock and watchdog
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // tests need well under a thousand cycles
  initial
  begin
    #(25 * 5000);
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    summarize();
  end

  // ==========================================================================
  // helpers
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // let field and input changes reach the registered outputs
  task automatic settle();
    repeat (2) @(negedge clk);
  endtask

  // one-cycle write strobe
  task automatic cfg_write(input logic [11:0] addr, input logic [3:0] lanes,
                           input logic [31:0] data);
    @(negedge clk);
    cfg_addr = addr;
    be       = lanes;
    wdata    = data;
    wr_en    = 1'b1;
    @(negedge clk);
    wr_en    = 1'b0;
  endtask

  // one-cycle read strobe, bounded wait for valid
  task automatic read_check(input logic [11:0] addr, input logic [31:0] exp,
                            input string what);
    int n;
    @(negedge clk);
    cfg_addr = addr;
    rd_en    = 1'b1;
    @(negedge clk);
    rd_en    = 1'b0;
    n        = 0;
    while (rd_valid !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    check(32'(rd_valid), 32'h1, "read valid");
    check(rdata, exp, what);
  endtask

  // power in thousandths, bench's own table
  function automatic int milli(input int v, input int s);
    int m[4] = '{1000, 100, 10, 1};
    return v * m[s];
  endfunction

  // ==========================================================================
  // main sequence
  initial
  begin
    rst_n       = 1'b0;
    clk_en      = 1'b1;
    cfg_addr    = 12'h000;
    wr_en       = 1'b0;
    be          = 4'h0;
    wdata       = 32'h0;
    rd_en       = 1'b0;
    eep_en      = 1'b0;
    eep_data    = 32'h0;
    min_val     = 8'h00;
    lim_valid   = 1'b0;
    lim_val     = 8'h00;
    lim_scale   = 2'h0;
    l1_req      = 1'b0;
    l1_active   = 1'b0;
    dstate_l1   = 1'b0;
    fails       = 0;
    comparisons = 0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;

    // reset value and unmapped read
    read_check(`GCC_CTRL_OFFSET, `GCC_RST_WORD, "reset word");
    read_check(12'h0BC, 32'h0, "unmapped read");
    $display("test reset done");

    // reserved bits, lanes, unmapped write, frozen clock
    // reserved write, then a read taken on the very next edge
    @(negedge clk);
    cfg_addr = `GCC_CTRL_OFFSET;
    be       = 4'hF;
    wdata    = 32'hEFFF_FFFF;
    wr_en    = 1'b1;
    @(negedge clk);
    wr_en    = 1'b0;
    rd_en    = 1'b1;
    @(negedge clk);
    rd_en    = 1'b0;
    check(32'(rd_valid), 32'h1, "back to back valid");
    check(rdata, 32'h6030_0000, "back to back read");
    read_check(`GCC_CTRL_OFFSET, 32'h6030_0000, "reserved read");
    cfg_write(12'h0BC, 4'hF, 32'h0);
    read_check(`GCC_CTRL_OFFSET, 32'h6030_0000, "unmapped write");
    cfg_write(`GCC_CTRL_OFFSET, 4'h8, 32'h0);
    read_check(`GCC_CTRL_OFFSET, 32'h0030_0000, "top lane");
    cfg_write(`GCC_CTRL_OFFSET, 4'h4, 32'h0);
    read_check(`GCC_CTRL_OFFSET, 32'h0, "mid lane");
    clk_en = 1'b0;
    cfg_write(`GCC_CTRL_OFFSET, 4'hF, 32'h6030_0000);
    clk_en = 1'b1;
    read_check(`GCC_CTRL_OFFSET, 32'h0, "frozen write");
    $display("test access done");

    // low power grant and capability follow enable
    l1_req = 1'b1;
    cfg_write(`GCC_CTRL_OFFSET, 4'h8, 32'h2000_0000);
    settle();
    check(32'(grant), 32'h1, "grant on");
    check(32'(cap_support), 32'h1, "cap on");
    cfg_write(`GCC_CTRL_OFFSET, 4'h8, 32'h0);
    settle();
    check(32'(grant), 32'h0, "grant off");
    check(32'(cap_support), 32'h0, "cap off");
    l1_req = 1'b0;
    $display("test link done");

    // pll power down over every select and state mix
    for (int k = 0; k < 8; k++)
    begin
      cfg_write(`GCC_CTRL_OFFSET, 4'h8, {1'b0, k[2], 30'h0});
      l1_active = k[1];
      dstate_l1 = k[0];
      settle();
      check(32'(pll_down), 32'(k[0] | (k[1] & k[2])), "pll down");
    end
    l1_active = 1'b0;
    dstate_l1 = 1'b0;
    $display("test pll done");

    // every scale code against one limit, then zero minimum
    min_val   = 8'h0B;
    lim_val   = 8'h0B;
    lim_scale = 2'h1;
    for (int s = 0; s < 4; s++)
    begin
      cfg_write(`GCC_CTRL_OFFSET, 4'h4, {10'h0, s[1:0], 20'h0});
      settle();
      check(32'(pwr_scale), 32'(s), "scale out");
      @(negedge clk);
      lim_valid = 1'b1;
      @(negedge clk);
      lim_valid = 1'b0;
      check(32'(over), 32'(milli(11, 1) > milli(11, s)), "over");
    end
    // limit at 1.0x against a minimum at 0.001x
    lim_scale = 2'h0;
    @(negedge clk);
    lim_valid = 1'b1;
    @(negedge clk);
    lim_valid = 1'b0;
    check(32'(over), 32'(milli(11, 0) > milli(11, 3)), "scale apart");
    min_val = 8'h00;
    settle();
    check(32'(over), 32'h0, "zero minimum");
    $display("test scale done");

    // eeprom load beats a write, then reset mid-run
    @(negedge clk);
    cfg_addr = `GCC_CTRL_OFFSET;
    be       = 4'hF;
    wdata    = 32'h0010_0000;
    eep_data = 32'h6020_0000;
    wr_en    = 1'b1;
    eep_en   = 1'b1;
    @(negedge clk);
    wr_en    = 1'b0;
    eep_en   = 1'b0;
    read_check(`GCC_CTRL_OFFSET, 32'h6020_0000, "eeprom load");
    check(32'(pwr_scale), 32'h2, "eeprom scale");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    read_check(`GCC_CTRL_OFFSET, `GCC_RST_WORD, "after reset");
    check(32'(pwr_scale), 32'h0, "scale reset");
    $display("test eeprom done");

    summarize();
  end

endmodule // gcc_ctrl_upper_test

`default_nettype wire
